//--- verif/cdcsr_host.sv
// Byte-level model of the serial host that drives the register bank
`timescale 1ns/100ps
module cdcsr_host (
	input  wire logic       ref_clk,
	output logic            bus_ptr_load,
	output logic            bus_wr,
	output logic            bus_rd,
	output logic      [7:0] bus_wdata,
	input  wire logic [7:0] bus_rdata,
	input  wire logic       bus_rvalid
);
	localparam logic H = 1'h1;
	localparam logic L = 1'h0;

	initial begin
		bus_ptr_load = L;
		bus_wr       = L;
		bus_rd       = L;
		bus_wdata    = 8'h00;
	end

	// Idle cycles show the inverted last byte, so a stale data line never passes for fresh data
	task automatic step(input logic p, input logic w, input logic r, input logic [7:0] d);
		@(negedge ref_clk);
		bus_ptr_load = p;
		bus_wr       = w;
		bus_rd       = r;
		bus_wdata    = (p | w | r) ? d : ~bus_wdata;
	endtask : step

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		step(H, L, L, a);
		step(L, H, L, d);
		step(L, L, L, 8'h00);
	endtask : write

	// One burst with no stop: upper byte lands first, lower byte follows through the pointer step
	task automatic write_code(input logic [9:0] c);
		step(H, L, L, cdcsr_pkg::ADDR_UPPER);
		step(L, H, L, {6'h00, c[9:8]});
		step(L, H, L, c[7:0]);
		step(L, L, L, 8'h00);
	endtask : write_code

	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		step(H, L, L, a);
		step(L, L, H, 8'h00);
		step(L, L, L, 8'h00);
		d = bus_rdata;
		v = bus_rvalid;
	endtask : read
endmodule : cdcsr_host

//--- verif/coil_driver_control_status_regs_test.sv
// Self-checking testbench of the coil driver register bank
`timescale 1ns/100ps
module coil_driver_control_status_regs_test;
	logic       ref_clk;
	logic       sys_rst;
	logic       clk_en;
	logic       run_req;
	logic [4:0] faults;
	logic       ptr_load;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	logic [9:0] code;
	logic       ring;
	logic       active;
	int         n_errors;
	int         checked;

	always #2 ref_clk = ~ref_clk;

	cdcsr_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_ptr_load(ptr_load),
		.bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata), .bus_rvalid(rvalid),
		.run_req(run_req), .fault_overcurrent(faults[0]), .fault_low_supply(faults[1]),
		.fault_coil_open(faults[2]), .fault_coil_short(faults[3]), .fault_thermal(faults[4]),
		.coil_current_code(code), .ring_comp_en(ring), .drive_active(active));

	cdcsr_host HOST (.ref_clk(ref_clk), .bus_ptr_load(ptr_load), .bus_wr(wr), .bus_rd(rd),
		.bus_wdata(wdata), .bus_rdata(rdata), .bus_rvalid(rvalid));

	// ****************************************
	// Checks and stimulus helpers
	// ****************************************
	task automatic chk_out(input string name, input logic [9:0] exp, input logic [9:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_out

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		HOST.read(a, d, v);
		chk_out("read valid", 10'h001, {9'h000, v});
		chk_out($sformatf("register %h", a), {2'h0, exp}, {2'h0, d});
	endtask : chk_rd

	task automatic set_in(input logic run, input logic [4:0] f, input int n);
		@(negedge ref_clk);
		run_req = run;
		faults  = f;
		repeat (n) @(negedge ref_clk);
	endtask : set_in

	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		ref_clk  = 1'h0;
		sys_rst  = 1'h1;
		clk_en   = 1'h1;
		run_req  = 1'h0;
		faults   = 5'h00;
		n_errors = 0;
		checked  = 0;
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'h0;
		chk_out("ring enable", 10'h001, {9'h000, ring});
		chk_out("active", 10'h000, {9'h000, active});
		chk_rd(cdcsr_pkg::ADDR_CTRL, 8'h02);
		chk_rd(cdcsr_pkg::ADDR_UPPER, 8'h00);
		chk_rd(cdcsr_pkg::ADDR_LOWER, 8'h00);
		chk_rd(cdcsr_pkg::ADDR_FLAGS, 8'h00);
		chk_rd(8'h00, 8'h00);
		chk_rd(8'h06, 8'h00);
		HOST.write(cdcsr_pkg::ADDR_CTRL, 8'hfc);
		chk_rd(cdcsr_pkg::ADDR_CTRL, 8'h00);
		chk_out("ring enable", 10'h000, {9'h000, ring});
		HOST.write(cdcsr_pkg::ADDR_UPPER, 8'hff);
		chk_out("code", 10'h000, code);
		chk_rd(cdcsr_pkg::ADDR_UPPER, 8'h03);
		HOST.write(cdcsr_pkg::ADDR_LOWER, 8'h5a);
		chk_out("code", 10'h35a, code);
		HOST.write_code(10'h1ff);
		chk_out("code", 10'h1ff, code);
		HOST.write_code(10'h3ff);
		chk_out("code", 10'h3ff, code);
		chk_rd(cdcsr_pkg::ADDR_LOWER, 8'hff);
		// Thermal is left out here: its flag drops by itself in standby once the input is low
		for (int i = 0; i < 4; i++) begin
			set_in(1'h0, 5'h01 << i, 0);
			set_in(1'h0, 5'h00, 0);
			chk_rd(cdcsr_pkg::ADDR_FLAGS, (8'h02 << i) - 8'h01);
		end
		set_in(1'h1, 5'h10, 4);
		chk_out("active", 10'h000, {9'h000, active});
		chk_rd(cdcsr_pkg::ADDR_FLAGS, 8'h1f);
		set_in(1'h1, 5'h00, 3);
		chk_out("active", 10'h001, {9'h000, active});
		chk_rd(cdcsr_pkg::ADDR_FLAGS, 8'h00);
		set_in(1'h1, 5'h10, 1);
		chk_out("active", 10'h000, {9'h000, active});
		set_in(1'h1, 5'h00, 3);
		chk_out("active", 10'h001, {9'h000, active});
		HOST.write(cdcsr_pkg::ADDR_CTRL, 8'h01);
		chk_out("active", 10'h000, {9'h000, active});
		chk_out("ring enable", 10'h001, {9'h000, ring});
		chk_out("code", 10'h000, code);
		chk_rd(cdcsr_pkg::ADDR_CTRL, 8'h02);
		chk_rd(cdcsr_pkg::ADDR_UPPER, 8'h00);
		chk_rd(cdcsr_pkg::ADDR_LOWER, 8'h00);
		// Clock enable low: a whole write must leave the bank untouched
		clk_en = 1'h0;
		HOST.write(cdcsr_pkg::ADDR_LOWER, 8'h77);
		clk_en = 1'h1;
		chk_out("code", 10'h000, code);
		chk_rd(cdcsr_pkg::ADDR_LOWER, 8'h00);
		summarize();
	end

	// Tests need about 113 cycles; 5000 leaves ample margin
	initial begin
		#20000;
		n_errors++;
		summarize();
	end
endmodule : coil_driver_control_status_regs_test

//--- verilog/cdcsr_flags.sv
// Sticky fault flag bank, one flip-flop per fault
`timescale 1ns/100ps
module cdcsr_flags #(
	parameter int NUM = 5
) (
	input  wire logic           ref_clk,
	input  wire logic           sys_rst,
	input  wire logic           clk_en,
	input  wire logic [NUM-1:0] fault_in,
	input  wire logic [NUM-1:0] flag_clr,
	output logic      [NUM-1:0] flags
);

	// ****************************************
	// Flags: a fault present in the clearing cycle wins
	// ****************************************
	for (genvar i = 0; i < NUM; i++) begin : g_flag
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				flags[i] <= 1'b0;
			end else if (clk_en) begin
				flags[i] <= fault_in[i] | (flags[i] & ~flag_clr[i]);
			end
		end
	end

endmodule : cdcsr_flags

//--- verilog/cdcsr_pkg.sv
// Package with register map, field layout, reset values and state codes of the coil driver register bank
package cdcsr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL  = 8'h02;
	localparam logic [7:0] ADDR_UPPER = 8'h03;
	localparam logic [7:0] ADDR_LOWER = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h05;
	localparam logic [7:0] PTR_RST    = 8'h00;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int         CTRL_SOFT_RST_BIT = 0;
	localparam int         CTRL_RING_EN_BIT  = 1;
	localparam logic       RING_EN_RST       = 1'b1;
	localparam int         CODE_W            = 10;
	localparam int         UPPER_W           = 2;
	localparam logic [1:0] UPPER_RST         = 2'h0;
	localparam logic [7:0] LOWER_RST         = 8'h00;
	localparam logic [9:0] CODE_RST          = 10'h000;
	localparam int         NUM_FLAGS         = 5;
	localparam logic [4:0] FLAGS_RST         = 5'h00;
	localparam int         FLAG_OVC_BIT      = 0;
	localparam int         FLAG_LOWSUP_BIT   = 1;
	localparam int         FLAG_OPEN_BIT     = 2;
	localparam int         FLAG_SHORT_BIT    = 3;
	localparam int         FLAG_THERM_BIT    = 4;

	// ****************************************
	// Operating state
	// ****************************************
	typedef enum logic [1:0] {
		ST_STANDBY = 2'b01,
		ST_ACTIVE  = 2'b10
	} cdcsr_state_t;

endpackage : cdcsr_pkg

//--- verilog/cdcsr_regs.sv
// Control and status register bank of the coil driver, with standby/active control
`timescale 1ns/100ps
module cdcsr_regs (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       bus_ptr_load,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata,
	output logic            bus_rvalid,
	input  wire logic       run_req,
	input  wire logic       fault_overcurrent,
	input  wire logic       fault_low_supply,
	input  wire logic       fault_coil_open,
	input  wire logic       fault_coil_short,
	input  wire logic       fault_thermal,
	output logic      [9:0] coil_current_code,
	output logic            ring_comp_en,
	output logic            drive_active
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0]                ptr_r;
	logic [1:0]                upper_r;
	logic [7:0]                lower_r;
	logic [9:0]                code_r;
	logic                      ring_en_r;
	logic [7:0]                rdata_r;
	logic                      rvalid_r;
	cdcsr_pkg::cdcsr_state_t   state_r;
	cdcsr_pkg::cdcsr_state_t   state_nxt;
	logic [4:0]                flags;
	wire logic                 acc_wr;
	wire logic                 acc_rd;
	wire logic                 hit_ctrl;
	wire logic                 hit_upper;
	wire logic                 hit_lower;
	wire logic                 hit_flags;
	wire logic                 soft_rst;
	wire logic                 wr_ctrl;
	wire logic                 wr_upper;
	wire logic                 wr_lower;
	wire logic                 in_standby;
	wire logic                 go_active;
	wire logic                 go_standby;
	wire logic [4:0]           fault_in;
	wire logic [4:0]           flag_clr;
	wire logic                 therm_clr;
	wire logic [7:0]           rd_mux;

	// ****************************************
	// Access decode
	// ****************************************
	// Pointer load takes priority over a data byte in the same cycle
	assign acc_wr    = clk_en & bus_wr & ~bus_ptr_load;
	assign acc_rd    = clk_en & bus_rd & ~bus_ptr_load;
	assign hit_ctrl  = (ptr_r == cdcsr_pkg::ADDR_CTRL);
	assign hit_upper = (ptr_r == cdcsr_pkg::ADDR_UPPER);
	assign hit_lower = (ptr_r == cdcsr_pkg::ADDR_LOWER);
	assign hit_flags = (ptr_r == cdcsr_pkg::ADDR_FLAGS);
	assign soft_rst  = acc_wr & hit_ctrl & bus_wdata[cdcsr_pkg::CTRL_SOFT_RST_BIT];
	assign wr_ctrl   = acc_wr & hit_ctrl & ~soft_rst;
	assign wr_upper  = acc_wr & hit_upper & ~soft_rst;
	assign wr_lower  = acc_wr & hit_lower & ~soft_rst;

	// Soft reset bit is never stored, so it reads back zero
	assign rd_mux = hit_ctrl  ? {6'h00, ring_en_r, 1'b0} :
	                hit_upper ? {6'h00, upper_r} :
	                hit_lower ? lower_r :
	                hit_flags ? {3'h0, flags} :
	                8'h00;

	// ****************************************
	// Register pointer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ptr_r <= cdcsr_pkg::PTR_RST;
		end else if (clk_en && bus_ptr_load) begin
			ptr_r <= bus_wdata;
		end else if (acc_wr || acc_rd) begin
			ptr_r <= ptr_r + 8'h01;
		end
	end

	// ****************************************
	// Control and current registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst || soft_rst) begin
			ring_en_r <= cdcsr_pkg::RING_EN_RST;
		end else if (wr_ctrl) begin
			ring_en_r <= bus_wdata[cdcsr_pkg::CTRL_RING_EN_BIT];
		end
	end

	// Upper bits are only staged; the drive sees them with the next lower write
	always_ff @(posedge ref_clk) begin
		if (sys_rst || soft_rst) begin
			upper_r <= cdcsr_pkg::UPPER_RST;
		end else if (wr_upper) begin
			upper_r <= bus_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || soft_rst) begin
			lower_r <= cdcsr_pkg::LOWER_RST;
			code_r  <= cdcsr_pkg::CODE_RST;
		end else if (wr_lower) begin
			lower_r <= bus_wdata;
			code_r  <= {upper_r, bus_wdata};
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else if (clk_en) begin
			rvalid_r <= acc_rd;
			if (acc_rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ****************************************
	// Standby / active control
	// ****************************************
	assign in_standby = (state_r == cdcsr_pkg::ST_STANDBY);
	assign go_active  = clk_en & in_standby & run_req & ~soft_rst & ~fault_thermal
	                    & ~flags[cdcsr_pkg::FLAG_THERM_BIT];
	assign go_standby = clk_en & ~in_standby & (soft_rst | fault_thermal | ~run_req);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			cdcsr_pkg::ST_STANDBY: begin
				if (go_active) begin
					state_nxt = cdcsr_pkg::ST_ACTIVE;
				end
			end
			cdcsr_pkg::ST_ACTIVE: begin
				if (go_standby) begin
					state_nxt = cdcsr_pkg::ST_STANDBY;
				end
			end
			default: begin
				state_nxt = cdcsr_pkg::ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= cdcsr_pkg::ST_STANDBY;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Fault flags
	// ****************************************
	// Thermal flag would otherwise lock the part in standby until a soft reset; it drops once cool in standby
	assign therm_clr = clk_en & in_standby & ~fault_thermal;
	assign fault_in  = {fault_thermal, fault_coil_short, fault_coil_open, fault_low_supply, fault_overcurrent};
	assign flag_clr  = {5{go_active | soft_rst}}
	                   | {therm_clr, 4'h0};

	cdcsr_flags #(
		.NUM (cdcsr_pkg::NUM_FLAGS)
	) u_flags (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.fault_in (fault_in),
		.flag_clr (flag_clr),
		.flags    (flags)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign bus_rdata         = rdata_r;
	assign bus_rvalid        = rvalid_r;
	assign coil_current_code = code_r;
	assign ring_comp_en      = ring_en_r;
	assign drive_active      = state_r[1];

	// ****************************************
	// Assertions
	// ****************************************
	AST_SOFT_RST_READS_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_rd && hit_ctrl |=> bus_rdata[0] == 1'b0 && bus_rvalid)
		else $error("Soft reset bit read back as one");

	AST_SOFT_RST_DEFAULTS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		soft_rst |=> ring_comp_en && coil_current_code == 10'h000 && !drive_active && upper_r == 2'h0)
		else $error("Soft reset did not restore defaults");

	AST_CODE_APPLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_lower |=> coil_current_code == {$past(upper_r), $past(bus_wdata)})
		else $error("Lower write did not apply full code");

	AST_UPPER_HOLDS_CODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_upper |=> $stable(coil_current_code))
		else $error("Current changed without lower write");

	AST_FLAGS_CLEAR_ON_ACTIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		go_active |=> drive_active && (flags & ~$past(fault_in)) == 5'h00)
		else $error("Flags not cleared on activation");

	AST_THERMAL_STANDBY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		clk_en && fault_thermal |=> !drive_active)
		else $error("Active while thermal fault present");

	AST_THERMAL_BLOCKS_ACTIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(drive_active) |-> !$past(flags[4]) && !$past(fault_thermal))
		else $error("Activated with thermal flag set");

	AST_STATUS_LAYOUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_rd && hit_flags |=> bus_rdata == {3'h0, $past(flags)})
		else $error("Status read layout wrong");

	AST_PTR_ADVANCE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(acc_wr || acc_rd) |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("Pointer did not advance");

	AST_RING_FOLLOWS_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_ctrl |=> ring_comp_en == $past(bus_wdata[1]))
		else $error("Ringing enable not written");

	AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		acc_rd && !(hit_ctrl || hit_upper || hit_lower || hit_flags) |=> bus_rdata == 8'h00)
		else $error("Unmapped read not zero");

endmodule : cdcsr_regs
